// ---- cfp_pkg.sv ----
// Function
// RL1: Divide input clock into four phases.
// RL2: Program counter advances phase one; capture phase four.
// RL3: Fetch overlaps execute; one instruction per cycle.
// RL4: Counter changes flush fetched word as no-op.
// RL5: Decode and execute during phases two to four; code decodes and requests reads in phase one.
// RL6: Operand read phase two, destination write phase four.
// RL7: Byte addressed program memory, step two, even.
// RL8: Absolute jump loads word address into bits 20:1.
// RL9: Relative branch offset counts words, doubled bytes.
// RL10: Second word top nibble ones, twelve data bits.
// RL11: Skipped first word makes second word no-op.
// RL12: Adding working value to low byte jumps.
// RL13: Table transfers move one byte via pointer, latch.
// RL14: Data addresses are twelve bits, 4096 bytes.
// RL15: Sixteen banks of 256; bank select low nibble.
// RL16: Special registers top of bank 15; unimplemented zero.
// RL17: Indirect pointers hold full twelve bit addresses.
// RL18: Register move takes two words, two cycles.
// RL19: Access bank reachable regardless of bank select.
// RL20: Low byte write loads, read copies, upper latches.
// RL21: Reset starts counter at zero, fetch only.
package cfp_pkg;

    localparam int PC_W = 21;
    localparam int DA_W = 12;
    localparam int WORD_W = 16;
    localparam int BANK_W = 4;
    localparam int PTR_NUM = 3;

    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [BANK_W-1:0] BANK_LOW = 4'h0;
    localparam logic [BANK_W-1:0] BANK_TOP = 4'hf;

    // Core register addresses in the top of bank 15.
    localparam logic [DA_W-1:0] CORE_BASE = 12'hfd8;
    localparam logic [DA_W-1:0] A_PCU_LATCH = 12'hffb;
    localparam logic [DA_W-1:0] A_PCH_LATCH = 12'hffa;
    localparam logic [DA_W-1:0] A_PCL = 12'hff9;
    localparam logic [DA_W-1:0] A_TPTR_U = 12'hff8;
    localparam logic [DA_W-1:0] A_TPTR_H = 12'hff7;
    localparam logic [DA_W-1:0] A_TPTR_L = 12'hff6;
    localparam logic [DA_W-1:0] A_TLATCH = 12'hff5;
    localparam logic [DA_W-1:0] A_WORK = 12'hfe8;
    localparam logic [DA_W-1:0] A_BANK = 12'hfe0;
    localparam logic [DA_W-1:0] A_PTR0_LOW = 12'hfe9;
    localparam logic [DA_W-1:0] A_PTR0_PORT = 12'hfef;
    localparam logic [DA_W-1:0] PTR_STRIDE = 12'h008;

    // Reset values.
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [BANK_W-1:0] BANK_RESET = 4'h0;

    // Instruction encodings.
    localparam logic [7:0] OP_JUMP = 8'hef;
    localparam logic [7:0] OP_LDPTR = 8'hee;
    localparam logic [7:0] OP_MOVLW = 8'h0e;
    localparam logic [7:0] OP_MOVLB = 8'h01;
    localparam logic [4:0] OP_BRANCH = 5'h1a;
    localparam logic [3:0] OP_MOVE = 4'hc;
    localparam logic [3:0] OP_SECOND = 4'hf;
    localparam logic [5:0] OP_ADD_WORKING_TO_FILE = 6'h09;
    localparam logic [6:0] OP_MOVWF = 7'h37;
    localparam logic [6:0] OP_TSTFSZ = 7'h33;
    localparam logic [WORD_W-1:0] OP_TBLRD = 16'h0008;
    localparam logic [WORD_W-1:0] OP_TBLWT = 16'h000c;

    typedef enum logic [3:0] {
        PH_ONE = 4'h1,
        PH_TWO = 4'h2,
        PH_THREE = 4'h4,
        PH_FOUR = 4'h8
    } cfp_phase_type;

    function automatic logic [DA_W-1:0] ptr_low_addr(input int n);
        return A_PTR0_LOW - DA_W'(n * PTR_STRIDE);
    endfunction

    function automatic logic [DA_W-1:0] ptr_port_addr(input int n);
        return A_PTR0_PORT - DA_W'(n * PTR_STRIDE);
    endfunction

endpackage

// ---- cfp_addr_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface cfp_addr_if;
    import cfp_pkg::*;
    logic [BANK_W-1:0] bank;
    logic access;
    logic [7:0] field;
    logic full_sel;
    logic [DA_W-1:0] full_addr;
    logic [PTR_NUM-1:0][DA_W-1:0] ptrs;
    logic [DA_W-1:0] addr;
    logic indirect;
    modport former(input bank, access, field, full_sel, full_addr, ptrs,
        output addr, indirect);
    modport core(output bank, access, field, full_sel, full_addr, ptrs,
        input addr, indirect);
endinterface
`default_nettype wire

// ---- cfp_phase_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
module cfp_phase_gen
    import cfp_pkg::*;
(
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Phase output.
    output cfp_phase_type o_phase
);
    cfp_phase_type next_phase;

    // RL1: four phase rotation.
    always_comb begin
        case (o_phase)
            PH_ONE: next_phase = PH_TWO;
            PH_TWO: next_phase = PH_THREE;
            PH_THREE: next_phase = PH_FOUR;
            PH_FOUR: next_phase = PH_ONE;
            default: next_phase = PH_ONE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_phase <= PH_ONE;
        end else begin
            o_phase <= next_phase;
        end
    end

    a_phase_rotate: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (o_phase == PH_ONE) |=> (o_phase == PH_TWO) ##1 (o_phase == PH_THREE)
        ##1 (o_phase == PH_FOUR) ##1 (o_phase == PH_ONE)) // RL1
        else $error("Phase sequence broken.");
endmodule
`default_nettype wire

// ---- cfp_addr_former.sv ----
`timescale 1ns/10ps
`default_nettype none
module cfp_addr_former
    import cfp_pkg::*;
(
    // Clock and reset, used only by checks.
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Address request and result.
    cfp_addr_if.former aif
);
    logic [DA_W-1:0] access_addr;
    logic [DA_W-1:0] direct_addr;
    logic [DA_W-1:0] raw_addr;

    // RL19: access bank split.
    assign access_addr = (aif.field < ACCESS_SPLIT) ? {BANK_LOW, aif.field}
        : {BANK_TOP, aif.field};
    // RL15: bank select forms upper bits.
    assign direct_addr = aif.access ? {aif.bank, aif.field} : access_addr;
    // RL14: full twelve bit operand.
    assign raw_addr = aif.full_sel ? aif.full_addr : direct_addr;

    // RL17: indirect port uses pointer.
    always_comb begin
        aif.addr = raw_addr;
        aif.indirect = 1'b0;
        for (int n = 0; n < PTR_NUM; n++) begin
            if (raw_addr == ptr_port_addr(n)) begin
                aif.addr = aif.ptrs[n];
                aif.indirect = 1'b1;
            end
        end
    end

    a_bank_select: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (aif.access && !aif.full_sel && !aif.indirect)
        |-> (aif.addr == {aif.bank, aif.field})) // RL15
        else $error("Banked address not formed from bank select.");
    a_access_bank: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (!aif.access && !aif.full_sel && !aif.indirect)
        |-> (aif.addr[11:8] == ((aif.field < ACCESS_SPLIT) ? BANK_LOW
        : BANK_TOP))) // RL19
        else $error("Access bank address wrong.");
endmodule
`default_nettype wire

// ---- cfp_core.sv ----
`timescale 1ns/10ps
`default_nettype none
module cfp_core
    import cfp_pkg::*;
(
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_b,
    // Program memory fetch port.
    output logic [PC_W-1:0] o_prog_addr,
    input wire logic [WORD_W-1:0] i_prog_word,
    // Table access port.
    output logic [PC_W-1:0] o_table_addr,
    output logic o_table_rd,
    output logic o_table_wr,
    output logic [7:0] o_table_wdata,
    input wire logic [7:0] i_table_byte,
    // Data memory port.
    output logic [DA_W-1:0] o_data_addr,
    output logic o_data_rd,
    output logic o_data_wr,
    output logic [7:0] o_data_wdata,
    input wire logic [7:0] i_data_rdata,
    // Timing status.
    output cfp_phase_type o_phase,
    output logic o_exec_valid
);
    logic [PC_W-1:0] pc;
    logic [WORD_W-1:0] ir;
    logic ir_valid;
    logic started;
    logic redirect;
    logic [PC_W-1:0] target;
    logic [7:0] work;
    logic [BANK_W-1:0] bank;
    logic [7:0] pch_latch;
    logic [4:0] pcu_latch;
    logic [PC_W-1:0] table_pointer;
    logic [7:0] table_latch;
    logic [PTR_NUM-1:0][DA_W-1:0] ptr;
    logic [7:0] operand;
    logic move_pending;
    logic [7:0] move_data;

    cfp_addr_if aif();

    cfp_phase_gen u_phase (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .o_phase(o_phase)
    );

    cfp_addr_former u_former (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .aif(aif)
    );

    assign o_prog_addr = pc;
    assign o_table_addr = table_pointer;
    assign o_table_wdata = table_latch;
    assign o_exec_valid = ir_valid;

    // Phase decode.
    wire ph1 = (o_phase == PH_ONE);
    wire ph2 = (o_phase == PH_TWO);
    wire ph3 = (o_phase == PH_THREE);
    wire ph4 = (o_phase == PH_FOUR);

    // Instruction decode.
    wire exec = ir_valid;
    wire is_jump = (ir[15:8] == OP_JUMP);
    wire is_ldptr = (ir[15:8] == OP_LDPTR);
    wire is_movlw = (ir[15:8] == OP_MOVLW);
    wire is_movlb = (ir[15:8] == OP_MOVLB);
    wire is_branch = (ir[15:11] == OP_BRANCH);
    wire is_move = (ir[15:12] == OP_MOVE);
    wire is_second = (ir[15:12] == OP_SECOND);
    wire is_add_working_to_file = (ir[15:10] == OP_ADD_WORKING_TO_FILE);
    wire is_movwf = (ir[15:9] == OP_MOVWF);
    wire is_tstfsz = (ir[15:9] == OP_TSTFSZ);
    wire is_tblrd = (ir == OP_TBLRD);
    wire is_tblwt = (ir == OP_TBLWT);
    // RL11: second word acts only after its first.
    wire move_second = exec && is_second && move_pending;

    // RL6: operand read and destination write.
    wire needs_read = exec && (is_add_working_to_file || is_tstfsz || is_move);
    wire needs_write = (exec && ((is_add_working_to_file && ir[9]) || is_movwf))
        || move_second;
    wire [8:0] add_full = operand + work;
    wire [7:0] write_value = move_second ? move_data
        : (is_add_working_to_file ? add_full[7:0] : work);

    // RL14: address request to the former.
    assign aif.bank = bank;
    assign aif.access = ir[8];
    assign aif.field = ir[7:0];
    assign aif.full_sel = is_move || move_second;
    assign aif.full_addr = ir[11:0];
    assign aif.ptrs = ptr;

    // RL16: core registers; unimplemented core locations read zero.
    wire core_hit = (o_data_addr >= CORE_BASE);
    logic [7:0] core_value;
    always_comb begin
        case (o_data_addr)
            A_WORK: core_value = work;
            A_BANK: core_value = {4'h0, bank};
            A_PCL: core_value = pc[7:0];
            A_PCH_LATCH: core_value = pch_latch;
            A_PCU_LATCH: core_value = {3'h0, pcu_latch};
            A_TPTR_L: core_value = table_pointer[7:0];
            A_TPTR_H: core_value = table_pointer[15:8];
            A_TPTR_U: core_value = {3'h0, table_pointer[20:16]};
            A_TLATCH: core_value = table_latch;
            default: core_value = 8'h00;
        endcase
        for (int n = 0; n < PTR_NUM; n++) begin
            if (o_data_addr == ptr_low_addr(n)) begin
                core_value = ptr[n][7:0];
            end
            if (o_data_addr == ptr_low_addr(n) + 12'h001) begin
                core_value = {4'h0, ptr[n][11:8]};
            end
        end
    end
    wire [7:0] read_value = core_hit ? core_value : i_data_rdata;

    // Core write strobe during phase four.
    wire wr_core = ph4 && o_data_wr;
    wire pcl_write = wr_core && (o_data_addr == A_PCL);
    wire pcl_read = ph2 && o_data_rd && (o_data_addr == A_PCL);

    // RL8: absolute jump target.
    wire [PC_W-1:0] jump_target = {i_prog_word[11:0], ir[7:0], 1'b0};
    // RL9: branch offset doubled.
    wire [PC_W-1:0] branch_target = pc + {{9{ir[10]}}, ir[10:0], 1'b0};
    // RL12: computed jump from low byte write.
    wire [PC_W-1:0] pcl_target = {pcu_latch, pch_latch,
        o_data_wdata[7:1], 1'b0};
    wire jump_now = exec && (is_jump || is_branch);
    wire skip_now = exec && is_tstfsz && (operand == 8'h00);
    wire ldptr_now = exec && is_ldptr;
    // RL4: flush the already fetched word.
    wire flush = jump_now || pcl_write || skip_now || ldptr_now;
    wire [PC_W-1:0] next_target = pcl_write ? pcl_target
        : (is_jump ? jump_target : branch_target);

    // RL2: counter advances at phase one.
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            pc <= PC_RESET;
            started <= 1'b0;
        end else if (ph1) begin
            // RL21: first cycle after reset only fetches.
            started <= 1'b1;
            // RL7: sequential step of two.
            if (started) begin
                pc <= redirect ? target : pc + PC_STEP;
            end
        end
    end

    // RL4: redirect held until phase one.
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            redirect <= 1'b0;
            target <= PC_RESET;
        end else if (ph4) begin
            redirect <= jump_now || pcl_write;
            target <= next_target;
        end else if (ph1) begin
            redirect <= 1'b0;
        end
    end

    // RL3: capture fetched word at phase four.
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            ir <= 16'h0000;
            ir_valid <= 1'b0;
        end else if (ph4) begin
            ir <= i_prog_word;
            ir_valid <= started && !flush;
        end
    end

    // RL18: register move carries its operand.
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            move_pending <= 1'b0;
            move_data <= 8'h00;
        end else if (ph4) begin
            move_pending <= exec && is_move;
            move_data <= operand;
        end
    end

    // RL6: data strobes, read in two, write in four.
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            o_data_rd <= 1'b0;
            o_data_wr <= 1'b0;
            o_data_addr <= 12'h000;
            o_data_wdata <= 8'h00;
        end else begin
            o_data_rd <= ph1 && needs_read;
            o_data_wr <= ph3 && needs_write;
            if ((ph1 && needs_read) || (ph3 && needs_write)) begin
                o_data_addr <= aif.addr;
            end
            if (ph3) begin
                o_data_wdata <= write_value;
            end
        end
    end

    // RL5: operand captured at end of phase two.
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            operand <= 8'h00;
        end else if (ph2 && o_data_rd) begin
            operand <= read_value;
        end
    end

    // Working register and bank select.
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            work <= WORK_RESET;
            bank <= BANK_RESET;
        end else if (ph4) begin
            if (wr_core && (o_data_addr == A_WORK)) begin
                work <= o_data_wdata;
            end else if (exec && is_add_working_to_file && !ir[9]) begin
                work <= add_full[7:0];
            end else if (exec && is_movlw) begin
                work <= ir[7:0];
            end
            // RL15: only four bank bits stored.
            if (wr_core && (o_data_addr == A_BANK)) begin
                bank <= o_data_wdata[3:0];
            end else if (exec && is_movlb) begin
                bank <= ir[3:0];
            end
        end
    end

    // RL20: upper latches load and copy.
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            pch_latch <= 8'h00;
            pcu_latch <= 5'h00;
        end else if (pcl_read) begin
            pch_latch <= pc[15:8];
            pcu_latch <= pc[20:16];
        end else if (wr_core) begin
            if (o_data_addr == A_PCH_LATCH) begin
                pch_latch <= o_data_wdata;
            end
            if (o_data_addr == A_PCU_LATCH) begin
                pcu_latch <= o_data_wdata[4:0];
            end
        end
    end

    // RL13: table pointer, latch and strobes.
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            table_pointer <= PC_RESET;
            table_latch <= 8'h00;
            o_table_rd <= 1'b0;
            o_table_wr <= 1'b0;
        end else begin
            o_table_rd <= ph1 && exec && is_tblrd;
            o_table_wr <= ph1 && exec && is_tblwt;
            if (o_table_rd) begin
                table_latch <= i_table_byte;
            end else if (wr_core && (o_data_addr == A_TLATCH)) begin
                table_latch <= o_data_wdata;
            end
            if (wr_core && (o_data_addr == A_TPTR_L)) begin
                table_pointer[7:0] <= o_data_wdata;
            end
            if (wr_core && (o_data_addr == A_TPTR_H)) begin
                table_pointer[15:8] <= o_data_wdata;
            end
            if (wr_core && (o_data_addr == A_TPTR_U)) begin
                table_pointer[20:16] <= o_data_wdata[4:0];
            end
        end
    end

    // RL17: pointer registers, loaded whole or by byte.
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            ptr <= '0;
        end else begin
            for (int n = 0; n < PTR_NUM; n++) begin
                if (wr_core && (o_data_addr == ptr_low_addr(n))) begin
                    ptr[n][7:0] <= o_data_wdata;
                end
                if (wr_core && (o_data_addr == ptr_low_addr(n) + 12'h001)) begin
                    ptr[n][11:8] <= o_data_wdata[3:0];
                end
            end
            // RL10: second word supplies low data bits.
            if (ph4 && ldptr_now && (i_prog_word[15:12] == OP_SECOND)) begin
                ptr[ir[5:4]] <= {ir[3:0], i_prog_word[7:0]};
            end
        end
    end

    a_pc_step: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (ph1 && started && !redirect) |=> (pc == $past(pc) + PC_STEP)) // RL7
        else $error("Counter did not step by two.");
    a_pc_even: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        pc[0] == 1'b0) // RL7
        else $error("Counter low bit set.");
    a_pc_phase_one: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        !ph1 |=> $stable(pc)) // RL2
        else $error("Counter changed outside phase one.");
    a_ir_phase_four: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        !ph4 |=> $stable(ir) && $stable(ir_valid)) // RL2
        else $error("Holding register changed outside phase four.");
    a_jump_target: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (ph4 && exec && is_jump) |=> redirect && (target ==
        {$past(i_prog_word[11:0]), $past(ir[7:0]), 1'b0})) // RL8
        else $error("Jump target wrong.");
    a_jump_flush: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (ph4 && jump_now) |=> !ir_valid ##1 (pc == $past(target))) // RL4
        else $error("Jump did not flush or redirect.");
    a_branch_double: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (ph4 && exec && is_branch) |=> (target == $past(pc)
        + {{9{$past(ir[10])}}, $past(ir[10:0]), 1'b0})) // RL9
        else $error("Branch displacement not doubled.");
    a_read_q2: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_data_rd |-> (o_phase == PH_TWO)) // RL6
        else $error("Data read outside phase two.");
    a_write_q4: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_data_wr |-> (o_phase == PH_FOUR)) // RL6
        else $error("Data write outside phase four.");
    a_lone_second: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (ph3 && exec && is_second && !move_pending) |=> !o_data_wr) // RL11
        else $error("Lone second word did not act as no-op.");
    a_pcl_copy: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        pcl_read |=> (pch_latch == $past(pc[15:8]))
        && (pcu_latch == $past(pc[20:16]))) // RL20
        else $error("Low byte read did not copy upper bytes.");
    a_reset_start: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        !started |-> (pc == PC_RESET) && !ir_valid) // RL21
        else $error("Reset start state wrong.");

    c_jump: cover property (@(posedge i_clock) disable iff (!i_rst_b)
        ph4 && exec && is_jump);
    c_move_pair: cover property (@(posedge i_clock) disable iff (!i_rst_b)
        ph4 && move_second);
    c_computed: cover property (@(posedge i_clock) disable iff (!i_rst_b)
        pcl_write);
    c_skip: cover property (@(posedge i_clock) disable iff (!i_rst_b)
        ph4 && skip_now);
endmodule
`default_nettype wire

// ---- cfp_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module cfp_mem_model
    import cfp_pkg::*;
(
    // Clock.
    input wire logic i_clock,
    // Program side.
    input wire logic [PC_W-1:0] i_prog_addr,
    output logic [WORD_W-1:0] o_prog_word,
    input wire logic [PC_W-1:0] i_table_addr,
    input wire logic i_table_rd,
    output logic [7:0] o_table_byte,
    // Data side.
    input wire logic [DA_W-1:0] i_data_addr,
    input wire logic i_data_rd,
    input wire logic i_data_wr,
    input wire logic [7:0] i_data_wdata,
    output logic [7:0] o_data_rdata
);
    logic [WORD_W-1:0] prog [0:255];
    logic [7:0] dmem [0:4095];
    logic [WORD_W-1:0] tword;
    logic [7:0] tsel;
    assign o_prog_word = prog[i_prog_addr[8:1]];
    assign tword = prog[i_table_addr[8:1]];
    assign tsel = i_table_addr[0] ? tword[15:8] : tword[7:0];
    assign o_table_byte = i_table_rd ? tsel : ~tsel;
    assign o_data_rdata = i_data_rd ? dmem[i_data_addr] : ~dmem[i_data_addr];
    always @(posedge i_clock) begin
        if (i_data_wr) begin
            dmem[i_data_addr] <= i_data_wdata;
        end
    end
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import cfp_pkg::*;
    logic i_clock;
    logic i_rst_b;
    int miscompares;
    int checked;
    wire logic [PC_W-1:0] pa, ta;
    wire logic [WORD_W-1:0] pw;
    wire logic [7:0] tbyte, wd, rd, twd;
    wire logic trd, drd, dwr, ev, twr;
    wire logic [DA_W-1:0] da;
    cfp_phase_type ph;
    cfp_core i_dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .o_prog_addr(pa),
        .i_prog_word(pw), .o_table_addr(ta), .o_table_rd(trd),
        .o_table_wr(twr), .o_table_wdata(twd), .i_table_byte(tbyte),
        .o_data_addr(da), .o_data_rd(drd), .o_data_wr(dwr),
        .o_data_wdata(wd), .i_data_rdata(rd), .o_phase(ph),
        .o_exec_valid(ev));
    cfp_mem_model i_mem (.i_clock(i_clock), .i_prog_addr(pa),
        .o_prog_word(pw), .i_table_addr(ta), .i_table_rd(trd),
        .o_table_byte(tbyte), .i_data_addr(da), .i_data_rd(drd),
        .i_data_wr(dwr), .i_data_wdata(wd), .o_data_rdata(rd));
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end
    function automatic logic [7:0] orig(input int a);
        return 8'(a) ^ 8'ha5;
    endfunction
    task automatic results;
        $display("checked %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %0h", $time, what, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic boot(input logic [15:0] w [$]);
        foreach (i_mem.prog[i]) begin
            i_mem.prog[i] = 16'h0000;
        end
        foreach (w[i]) begin
            i_mem.prog[i] = w[i];
        end
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_rst_b <= 1'b1;
        #1;
    endtask
    task automatic wait_for(input int k, input logic [PC_W-1:0] t,
        output int n);
        logic [4:0] s;
        for (n = 0; n <= 64; n++) begin
            s = {twr, pa === t, trd, drd, dwr};
            if (s[k] === 1'b1) begin
                return;
            end
            step(1);
        end
        cmp(0, 1, "wait");
        results;
    endtask
    task automatic redirect(input logic [15:0] w [$], input int t,
        input int when, input int hit, input int lost, input int val);
        int n;
        boot(w);
        wait_for(3, 21'(t), n);
        cmp(n, when, "redirect time");
        step(12);
        cmp(i_mem.dmem[lost], orig(lost), "flushed word");
        cmp(i_mem.dmem[hit], val, "target word");
        $display("test redirect to %0h done", t);
    endtask
    task automatic t_phases;
        boot('{16'h0e55});
        for (int c = 0; c < 8; c++) begin
            cmp(ph, 32'h1 << (c % 4), "phase");
            cmp(pa, (c < 5) ? 0 : 2, "start pc");
            if (c == 0 || c == 4) begin
                cmp(ev, c == 4, "exec valid");
            end
            step(1);
        end
        $display("test phases done");
    endtask
    task automatic t_store;
        int n;
        boot('{16'h0e55, 16'h6e10});
        wait_for(0, 0, n);
        cmp(n, 11, "write cycle");
        cmp(ph, PH_FOUR, "write phase");
        cmp(da, 12'h010, "write addr");
        cmp(wd, 8'h55, "write data");
        $display("test store done");
    endtask
    task automatic t_jump;
        redirect('{16'hef04, 16'hf000, 16'h6e11, 0, 16'h6e12}, 8, 9, 'h12,
            'h11, 0);
    endtask
    task automatic t_branch;
        redirect('{16'hd003, 16'h6e16, 0, 0, 16'h6e15}, 8, 9, 'h15, 'h16,
            0);
    endtask
    task automatic t_compute;
        redirect('{16'h0e06, 16'h26f9, 16'h6e18, 0, 0, 16'h6e17}, 'ha, 13,
            'h17, 'h18, 6);
    endtask
    task automatic t_skip;
        i_mem.dmem[12'h020] = 8'h00;
        boot('{16'h6620, 16'hc011, 16'hf013, 16'hc521, 16'hf322, 16'h6e14});
        step(40);
        cmp(i_mem.dmem[12'h013], orig('h13), "skipped move");
        cmp(i_mem.dmem[12'h322], orig('h521), "move");
        cmp(i_mem.dmem[12'h014], 0, "after move");
        $display("test skip done");
    endtask
    task automatic t_bank;
        int n;
        boot('{16'h0105, 16'h0e3c, 16'h2734, 16'hee07, 16'hf045, 16'h6eef,
            16'h6ef0});
        wait_for(1, 0, n);
        cmp(ph, PH_TWO, "read phase");
        cmp(da, 12'h534, "banked addr");
        step(40);
        cmp(i_mem.dmem[12'h534], orig('h534) + 8'h3c, "sum");
        cmp(i_mem.dmem[12'h745], 8'h3c, "indirect");
        cmp(i_mem.dmem[12'hff0], 8'h3c, "access top");
        $display("test bank done");
    endtask
    task automatic t_table;
        int n;
        boot('{16'h0e09, 16'h6ef6, 16'h0008, 16'hcff5, 16'hf019,
            16'h000c});
        wait_for(2, 0, n);
        cmp(ta, 9, "table addr");
        wait_for(4, 0, n);
        cmp(n, 12, "table write time");
        cmp(twd, 8'hf0, "table write latch");
        cmp(i_mem.dmem[12'h019], 8'hf0, "table byte");
        $display("test table done");
    endtask
    initial begin
        miscompares = 0;
        checked = 0;
        for (int i = 0; i < 4096; i++) begin
            i_mem.dmem[i] = orig(i);
        end
        t_phases;
        t_store;
        t_jump;
        t_branch;
        t_compute;
        t_skip;
        t_bank;
        t_table;
        results;
    end
endmodule
`default_nettype wire
